// File: logic/edge_counter_pkg.sv
// Package with constants and types for the pulse edge counter
package edge_counter_pkg;
   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int NARROW_W = 16;
   localparam int WIDE_W = 32;
   localparam int TASK_DIV_W = 16;
   // ---------------------------------------------------------------
   // Defaults and reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] TASK_DIV_DEF = 16'h4E20;
   localparam logic [31:0] MAX_DEF = 32'h0000FFFF;
   localparam logic [31:0] INIT_DEF = 32'h00000000;
   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_sel_t;
   typedef enum logic [0:0] {
      MODE_SINGLE = 1'h0,
      MODE_DIR = 1'h1
   } count_mode_t;
endpackage : edge_counter_pkg

// File: logic/edge_sense.sv
// Input synchroniser and edge detector for pulse, direction and reset
`timescale 1ns/1ns
module edge_sense
   import edge_counter_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic pulse_in, // Pulse train
   input wire logic dir_in, // Direction level
   input wire logic ext_reset_in, // External reset signal
   input wire edge_counter_pkg::edge_sel_t pulse_sel, // Pulse edge sensitivity
   input wire edge_counter_pkg::edge_sel_t reset_sel, // Reset edge sensitivity
   edge_sense_if.src ev // Detected events
);
   import edge_counter_pkg::*;

   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic [2:0] prev_q;
   wire [2:0] raw = {ext_reset_in, dir_in, pulse_in};

   // Two flops per input, then one more stage for edge compare
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
         prev_q <= 3'h0;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   function automatic logic edge_hit(input edge_sel_t sel, input logic now, input logic was);
      edge_hit = ((sel == EDGE_RISE || sel == EDGE_BOTH) && now && !was) ||
                 ((sel == EDGE_FALL || sel == EDGE_BOTH) && !now && was);
   endfunction : edge_hit

   // Rise is 0 to nonzero, fall is nonzero to 0 on the synchronised level
   assign ev.pulse_edge = edge_hit(pulse_sel, sync_q[0], prev_q[0]);
   assign ev.dir_level = sync_q[1];
   assign ev.reset_edge = edge_hit(reset_sel, sync_q[2], prev_q[2]);
endmodule : edge_sense

// File: logic/edge_sense_if.sv
// Interface carrying synchronised input events to the counter core
`timescale 1ns/1ns
interface edge_sense_if;
   logic pulse_edge;
   logic dir_level;
   logic reset_edge;
   modport src (output pulse_edge, output dir_level, output reset_edge);
   modport dst (input pulse_edge, input dir_level, input reset_edge);
endinterface : edge_sense_if

// File: logic/pulse_edge_counter.sv
// Up/down edge counter with wrap, external reset and per-task sampling
`timescale 1ns/1ns
module pulse_edge_counter
   import edge_counter_pkg::*;
#(
   parameter bit WIDE_UNIT = 1'b0, // Set on the one 32-bit unit
   parameter int CNT_W = WIDE_UNIT ? WIDE_W : NARROW_W,
   parameter logic [TASK_DIV_W-1:0] TASK_DIV = TASK_DIV_DEF // Clocks per control task
)
(
   input wire logic clk, // System clock, 20 MHz
   input wire logic rst, // Async reset, active high
   input wire logic pulse_in, // Pulse train
   input wire logic dir_in, // Direction level
   input wire logic ext_reset_in, // External reset signal
   input wire edge_counter_pkg::edge_sel_t pulse_sel, // Pulse edge sensitivity
   input wire edge_counter_pkg::edge_sel_t reset_sel, // Reset edge sensitivity
   input wire edge_counter_pkg::count_mode_t mode, // Single or direction mode
   input wire logic [CNT_W-1:0] max_val, // Wrap maximum
   input wire logic [CNT_W-1:0] init_val, // Initial value
   output logic [CNT_W-1:0] count_out, // Sampled count
   output logic sample_tick // Task period pulse
);
   import edge_counter_pkg::*;

   // ---------------------------------------------------------------
   // Input events
   // ---------------------------------------------------------------
   edge_sense_if ev_if ();

   edge_sense u_sense (
      .clk(clk),
      .rst(rst),
      .pulse_in(pulse_in),
      .dir_in(dir_in),
      .ext_reset_in(ext_reset_in),
      .pulse_sel(pulse_sel),
      .reset_sel(reset_sel),
      .ev(ev_if.src)
   );

   // ---------------------------------------------------------------
   // Counter core
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_INIT = 2'b01,
      ST_RUN = 2'b10
   } state_t;

   state_t state_q;
   state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] out_q;
   logic [TASK_DIV_W-1:0] div_q;

   wire count_up = (mode == MODE_SINGLE) ? 1'b1 : ev_if.dir_level;
   wire at_max = (cnt_q == max_val);
   wire at_zero = (cnt_q == '0);
   wire task_hit = (div_q == TASK_DIV - 1'b1);

   // Init loads the start value once after reset; then run
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         ST_INIT: begin
            cnt_d = init_val;
            state_d = ST_RUN;
         end
         ST_RUN: begin
            if (ev_if.reset_edge) begin
               cnt_d = init_val;
            end else if (ev_if.pulse_edge) begin
               if (count_up) begin
                  cnt_d = at_max ? '0 : cnt_q + 1'b1;
               end else begin
                  cnt_d = at_zero ? max_val : cnt_q - 1'b1;
               end
            end
         end
         default: begin
            state_d = ST_INIT;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_INIT;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // Task period sampling
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q <= '0;
         out_q <= '0;
      end else begin
         div_q <= task_hit ? '0 : div_q + 1'b1;
         if (task_hit) begin
            out_q <= cnt_q;
         end
      end
   end

   assign count_out = out_q;
   assign sample_tick = task_hit;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_run_reset;
      state_q == ST_RUN && ev_if.reset_edge;
   endsequence

   a_reset_loads_init: assert property (s_run_reset |=> cnt_q == $past(init_val))
      else $error("reset edge did not load initial value");
   a_reset_wins_count: assert property ((s_run_reset and ev_if.pulse_edge) |=> cnt_q == $past(init_val))
      else $error("reset edge lost to count edge");
   a_up_wrap_zero: assert property (state_q == ST_RUN && !ev_if.reset_edge && ev_if.pulse_edge && count_up
         && at_max |=> cnt_q == '0)
      else $error("upward wrap did not give zero");
   a_down_wrap_max: assert property (state_q == ST_RUN && !ev_if.reset_edge && ev_if.pulse_edge && !count_up
         && at_zero |=> cnt_q == $past(max_val))
      else $error("downward wrap did not give maximum");
   a_single_counts_up: assert property (state_q == ST_RUN && mode == MODE_SINGLE && !ev_if.reset_edge
         && ev_if.pulse_edge && !at_max |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("single mode did not increment");
   a_dir_low_down: assert property (state_q == ST_RUN && mode == MODE_DIR && !ev_if.dir_level
         && !ev_if.reset_edge && ev_if.pulse_edge && !at_zero |=> cnt_q == $past(cnt_q) - 1'b1)
      else $error("direction low did not decrement");
   a_idle_holds: assert property (state_q == ST_RUN && !ev_if.reset_edge && !ev_if.pulse_edge
         |=> $stable(cnt_q))
      else $error("count moved without an edge");
   a_none_no_reset: assert property (reset_sel == EDGE_NONE |-> !ev_if.reset_edge)
      else $error("reset edge seen with selection none");
   a_init_after_start: assert property (state_q == ST_INIT |=> cnt_q == $past(init_val))
      else $error("start did not load initial value");
   a_sample_count: assert property (task_hit |=> count_out == $past(cnt_q))
      else $error("sample did not capture count");
   a_sample_hold: assert property (!task_hit |=> $stable(count_out))
      else $error("count output moved between samples");
   a_rise_detect: assert property (reset_sel == EDGE_RISE && state_q == ST_RUN
         && $rose(u_sense.sync_q[2]) |=> cnt_q == $past(init_val))
      else $error("reset rising edge not honoured");

   // A counting edge that no reset edge overrides
   sequence s_count_edge;
      state_q == ST_RUN && !ev_if.reset_edge && ev_if.pulse_edge;
   endsequence

   sequence s_dir_up_edge;
      mode == MODE_DIR && ev_if.dir_level && !at_max;
   endsequence

   a_dir_high_up: assert property ((s_count_edge and s_dir_up_edge)
         |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("direction high did not increment");

   // ---------------------------------------------------------------
   // Edge detection checks
   // ---------------------------------------------------------------

   sequence s_fall_reset;
      reset_sel == EDGE_FALL && state_q == ST_RUN && $fell(u_sense.sync_q[2]);
   endsequence

   a_fall_detect: assert property (s_fall_reset |=> cnt_q == $past(init_val))
      else $error("reset falling edge not honoured");
   a_fall_ignored: assert property (reset_sel == EDGE_RISE
         && $fell(u_sense.sync_q[2]) |-> !ev_if.reset_edge)
      else $error("falling reset acted with rise selection");
   a_pulse_none: assert property (pulse_sel == EDGE_NONE |-> !ev_if.pulse_edge)
      else $error("pulse edge seen with selection none");
   a_pulse_rise_seen: assert property (pulse_sel == EDGE_RISE
         && $rose(u_sense.sync_q[0]) |-> ev_if.pulse_edge)
      else $error("pulse rising edge missed");
   a_pulse_fall_seen: assert property (pulse_sel == EDGE_FALL
         && $fell(u_sense.sync_q[0]) |-> ev_if.pulse_edge)
      else $error("pulse falling edge missed");
   a_pulse_both_seen: assert property (pulse_sel == EDGE_BOTH
         && $changed(u_sense.sync_q[0]) |-> ev_if.pulse_edge)
      else $error("pulse edge missed with both selected");
   // Two flops from pin to compare; reset only ever clears them
   a_pulse_sync_delay: assert property (u_sense.sync_q[0] |-> $past(pulse_in, 2))
      else $error("pulse level not two flops behind pin");
   a_dir_sync_delay: assert property (ev_if.dir_level |-> $past(dir_in, 2))
      else $error("direction level not two flops behind pin");

   // ---------------------------------------------------------------
   // Start and sampling checks
   // ---------------------------------------------------------------

   a_init_then_run: assert property (state_q == ST_INIT |=> state_q == ST_RUN)
      else $error("start state not left");
   a_div_in_range: assert property (div_q < TASK_DIV)
      else $error("task divider out of range");
   a_tick_single: assert property (task_hit |=> !task_hit)
      else $error("sample pulse longer than one cycle");
endmodule : pulse_edge_counter

// File: sim/pulse_source.sv
// Model of the pulse, direction and reset sources
`timescale 1ns/1ns
module pulse_source (
   input wire logic clk, // System clock
   output logic pulse_in, // Pulse train
   output logic dir_in, // Direction level
   output logic ext_reset_in // Reset signal
);
   initial begin
      pulse_in = 1'b0;
      dir_in = 1'b0;
      ext_reset_in = 1'b0;
   end
   // ---------------------------------------------------------------
   // Sources
   // ---------------------------------------------------------------
   // Levels held two clocks so the synchroniser sees each one
   task automatic pulses(input int n, input logic up);
      repeat (n) begin
         @(posedge clk);
         dir_in <= up;
         @(posedge clk);
         pulse_in <= 1'b1;
         repeat (2) @(posedge clk);
         pulse_in <= 1'b0;
         @(posedge clk);
      end
   endtask : pulses
   task automatic toggle;
      @(posedge clk);
      ext_reset_in <= ~ext_reset_in;
      repeat (2) @(posedge clk);
   endtask : toggle
   // Reset and pulse change on one edge
   task automatic together;
      @(posedge clk);
      pulse_in <= 1'b1;
      ext_reset_in <= ~ext_reset_in;
      repeat (2) @(posedge clk);
      pulse_in <= 1'b0;
      @(posedge clk);
   endtask : together
endmodule : pulse_source

// File: sim/test_pulse_edge_counter.sv
// Testbench for the pulse edge counter
`timescale 1ns/1ns
module test_pulse_edge_counter;
   import edge_counter_pkg::*;
   logic clk;
   logic rst;
   logic pulse_in;
   logic dir_in;
   logic ext_reset_in;
   edge_sel_t pulse_sel;
   edge_sel_t reset_sel;
   count_mode_t mode;
   logic [15:0] max_val;
   logic [15:0] init_val;
   logic [15:0] count_out;
   logic sample_tick;
   logic [31:0] wide_max;
   logic [31:0] wide_init;
   logic [31:0] wide_count;
   int miscompares;
   int checks_done;
   pulse_source src (.clk(clk), .pulse_in(pulse_in), .dir_in(dir_in), .ext_reset_in(ext_reset_in));
   pulse_edge_counter #(.WIDE_UNIT(1'b0), .TASK_DIV(16'h0008)) DUT (.clk(clk), .rst(rst), .pulse_in(pulse_in),
      .dir_in(dir_in), .ext_reset_in(ext_reset_in), .pulse_sel(pulse_sel), .reset_sel(reset_sel), .mode(mode),
      .max_val(max_val), .init_val(init_val), .count_out(count_out), .sample_tick(sample_tick));
   pulse_edge_counter #(.WIDE_UNIT(1'b1), .TASK_DIV(16'h0008)) wide_dut (.clk(clk), .rst(rst), .pulse_in(pulse_in),
      .dir_in(dir_in), .ext_reset_in(ext_reset_in), .pulse_sel(pulse_sel), .reset_sel(reset_sel), .mode(mode),
      .max_val(wide_max), .init_val(wide_init), .count_out(wide_count), .sample_tick());
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic next_tick(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (sample_tick !== 1'b1 && n < 20);
      if (n >= 20)
         miscompares++;
   endtask : next_tick
   // Pipeline drains before the sample is taken
   task automatic expect_count(input string nm, input logic [15:0] exp);
      int n;
      repeat (4) @(posedge clk);
      next_tick(n);
      @(posedge clk);
      #1;
      check(nm, count_out, exp);
   endtask : expect_count
   task automatic cfg(input edge_sel_t p, input edge_sel_t r, input count_mode_t m);
      @(posedge clk);
      pulse_sel <= p;
      reset_sel <= r;
      mode <= m;
   endtask : cfg
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_count;
      int gap;
      expect_count("init", 16'h0005);
      next_tick(gap);
      next_tick(gap);
      check("tick_gap", 16'(gap), 16'h0008);
      src.pulses(3, 1'b0);
      expect_count("single_rise", 16'h0008);
      cfg(EDGE_FALL, EDGE_NONE, MODE_SINGLE);
      src.pulses(2, 1'b0);
      expect_count("fall", 16'h000A);
      cfg(EDGE_BOTH, EDGE_NONE, MODE_SINGLE);
      src.pulses(2, 1'b1);
      expect_count("both", 16'h000E);
      cfg(EDGE_NONE, EDGE_NONE, MODE_SINGLE);
      src.pulses(2, 1'b1);
      src.toggle;
      expect_count("none", 16'h000E);
   endtask : t_count
   task automatic t_reset;
      cfg(EDGE_RISE, EDGE_FALL, MODE_SINGLE);
      src.toggle;
      expect_count("fall_reset", 16'h0005);
      cfg(EDGE_RISE, EDGE_RISE, MODE_SINGLE);
      src.pulses(1, 1'b0);
      src.toggle;
      expect_count("rise_reset", 16'h0005);
      src.pulses(1, 1'b0);
      src.toggle;
      expect_count("rise_only", 16'h0006);
      cfg(EDGE_RISE, EDGE_BOTH, MODE_SINGLE);
      src.toggle;
      expect_count("either_reset", 16'h0005);
   endtask : t_reset
   task automatic t_wrap;
      @(posedge clk);
      init_val <= 16'h0000;
      max_val <= 16'h0003;
      cfg(EDGE_RISE, EDGE_BOTH, MODE_DIR);
      src.toggle;
      expect_count("new_init", 16'h0000);
      src.pulses(1, 1'b0);
      expect_count("down_wrap", 16'h0003);
      src.pulses(1, 1'b1);
      expect_count("up_wrap", 16'h0000);
      src.pulses(2, 1'b1);
      src.pulses(1, 1'b0);
      expect_count("dir", 16'h0001);
      src.together;
      expect_count("priority", 16'h0000);
   endtask : t_wrap
   // Wide unit carries past 16 bits where the narrow one would roll over
   task automatic t_wide;
      cfg(EDGE_RISE, EDGE_BOTH, MODE_SINGLE);
      src.toggle;
      src.pulses(1, 1'b0);
      expect_count("narrow_after", 16'h0001);
      check("wide_high", wide_count[31:16], 16'h0001);
      check("wide_low", wide_count[15:0], 16'h0000);
   endtask : t_wide
   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      pulse_sel = EDGE_RISE;
      reset_sel = EDGE_NONE;
      mode = MODE_SINGLE;
      max_val = 16'h0020;
      init_val = 16'h0005;
      wide_max = 32'hFFFFFFFF;
      wide_init = 32'h0000FFFF;
      miscompares = 0;
      checks_done = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_count;
      t_reset;
      t_wrap;
      t_wide;
      report_and_stop;
   end
   // About seventeen times the expected run of roughly 300 clocks
   initial begin
      #250000;
      miscompares++;
      report_and_stop;
   end
endmodule : test_pulse_edge_counter
